// ===== two_wire_pkg.sv
// package: register map, status codes, field positions and timing of the two-wire unit
package two_wire_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [11:0] CONTROL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] SHIFT_OFS = 12'h008;
    localparam logic [11:0] ADDR_OFS = 12'h00C;
    localparam logic [11:0] DIV_OFS = 12'h010;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h014;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h018;
    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int CTL_PEND = 7;
    localparam int CTL_ACKEN = 6;
    localparam int CTL_START = 5;
    localparam int CTL_STOP = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN = 2;
    localparam logic [7:0] STATUS_MASK = 8'hF8;
    localparam logic [7:0] DIV_RESET = 8'h0A;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    // ------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------
    localparam logic [4:0] ST_START = 5'h01;
    localparam logic [4:0] ST_RSTART = 5'h02;
    localparam logic [4:0] ST_SLAW_ACK = 5'h03;
    localparam logic [4:0] ST_SLAW_NACK = 5'h04;
    localparam logic [4:0] ST_DATW_ACK = 5'h05;
    localparam logic [4:0] ST_DATW_NACK = 5'h06;
    localparam logic [4:0] ST_ARB_LOST = 5'h07;
    localparam logic [4:0] ST_SLAR_ACK = 5'h08;
    localparam logic [4:0] ST_SLAR_NACK = 5'h09;
    localparam logic [4:0] ST_DATR_ACK = 5'h0A;
    localparam logic [4:0] ST_DATR_NACK = 5'h0B;
    localparam logic [4:0] ST_SR_ADDR = 5'h0C;
    localparam logic [4:0] ST_SR_DATA_ACK = 5'h10;
    localparam logic [4:0] ST_SR_DATA_NACK = 5'h11;
    localparam logic [4:0] ST_SR_STOP = 5'h14;
    localparam logic [4:0] ST_ST_ADDR = 5'h15;
    localparam logic [4:0] ST_ST_DATA_ACK = 5'h17;
    localparam logic [4:0] ST_ST_DATA_NACK = 5'h18;
    localparam logic [4:0] ST_IDLE = 5'h1F;
    localparam logic [4:0] ST_BUS_ERR = 5'h00;
    // interrupt status bit positions
    localparam int IRQ_PEND = 0;
    localparam int IRQ_WCOL = 1;
    localparam int IRQ_W = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    // byte phase of the engine
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_START = 3'b001,
        PH_BITS = 3'b011,
        PH_ACK = 3'b010,
        PH_HOLD = 3'b110,
        PH_STOP = 3'b111,
        PH_SLAVE = 3'b101
    } phase_t;
    // apb request bundle
    typedef struct packed {
        logic sel;
        logic en;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;
    // bus pins
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } pin_out_t;
endpackage

// ===== two_wire_mode_status_sequencer.sv
// top module: two-wire unit with master/slave roles, status posting and apb registers
// Behaviour
// - four roles, master and slave, tx and rx
// - slave receive when addressed for write
// - direction bit high read, low write
// - ack low, not-ack high in ack slot
// - one byte per packet then ack
// - set pending, post code over prescaler field
// - transfer held while pending set
// - pending after byte out and ack in
// - stop request plus clear makes stop
// - after start post code 0x08
// - shift write while not pending discarded, collision
// - repeated start posts 0x10, bus kept
//
// The implementer's own choices: the address map and the APB register port.
module two_wire_mode_status_sequencer
    import two_wire_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    initial begin
        if (DIV_W < 2 || DIV_W > 16) begin
            $error("DIV_W out of range");
        end
    end
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic scl_prev_q;
    logic sda_prev_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_prev_q <= scl_s_q[1];
            sda_prev_q <= sda_s_q[1];
        end
    end
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl = scl_s_q[1];
    assign sda = sda_s_q[1];
    assign scl_rise = scl && !scl_prev_q;
    assign scl_fall = !scl && scl_prev_q;
    assign bus_start = scl && scl_prev_q && sda_prev_q && !sda;
    assign bus_stop = scl && scl_prev_q && !sda_prev_q && sda;
    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    apb_req_t req;
    assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    assign wr_acc = req.sel && req.en && req.wr;
    assign rd_acc = req.sel && req.en && !req.wr;
    assign pready = 1'b1;
    assign mapped = req.addr inside {CONTROL_OFS, STATUS_OFS, SHIFT_OFS, ADDR_OFS, DIV_OFS,
                                     IRQ_STAT_OFS, IRQ_MASK_OFS};
    assign pslverr = req.sel && req.en && !mapped;
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction
    // ------------------------------------------------------------
    // control and status state
    // ------------------------------------------------------------
    logic pend_q;
    logic acken_q;
    logic start_q;
    logic stop_q;
    logic wcol_q;
    logic en_q;
    logic [4:0] code_q;
    logic [1:0] presc_q;
    logic [7:0] shift_q;
    logic [6:0] own_q;
    logic [DIV_W-1:0] div_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic post;
    logic [4:0] post_code;
    logic stop_done;
    logic ctl_wr;
    logic shift_wr;
    assign ctl_wr = wr_acc && hit(req.addr, CONTROL_OFS);
    assign shift_wr = wr_acc && hit(req.addr, SHIFT_OFS);
    // write-one clears pending; post wins over clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (post) begin
            pend_q <= 1'b1;
        end else if (ctl_wr && req.wdata[CTL_PEND]) begin
            pend_q <= 1'b0;
        end
    end
    // code only changes at a post
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_q <= ST_IDLE;
        end else if (post) begin
            code_q <= post_code;
        end
    end
    // control bits; stop request self-clears once the stop is sent
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acken_q <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            if (ctl_wr) begin
                acken_q <= req.wdata[CTL_ACKEN];
                start_q <= req.wdata[CTL_START];
                en_q <= req.wdata[CTL_EN];
            end
            if (stop_done) begin
                stop_q <= 1'b0;
            end else if (ctl_wr) begin
                stop_q <= req.wdata[CTL_STOP];
            end
        end
    end
    // shift writes only while pending, else collision
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wcol_q <= 1'b0;
        end else if (shift_wr && !pend_q) begin
            wcol_q <= 1'b1;
        end else if (ctl_wr && !req.wdata[CTL_WCOL]) begin
            wcol_q <= 1'b0;
        end
    end
    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_q <= 2'b00;
            own_q <= OWN_ADDR_RESET;
            div_q <= DIV_W'(DIV_RESET);
            irq_mask_q <= 3'b000;
        end else if (wr_acc) begin
            if (hit(req.addr, STATUS_OFS)) begin
                presc_q <= req.wdata[1:0];
            end
            if (hit(req.addr, ADDR_OFS)) begin
                own_q <= req.wdata[6:0];
            end
            if (hit(req.addr, DIV_OFS)) begin
                div_q <= req.wdata[DIV_W-1:0];
            end
            if (hit(req.addr, IRQ_MASK_OFS)) begin
                irq_mask_q <= req.wdata[2:0];
            end
        end
    end
    // sticky events, cleared by reading; a new event wins over the read
    logic [2:0] irq_ev;
    assign irq_ev = {stop_done, shift_wr && !pend_q, post};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_q <= 3'b000;
        end else if (rd_acc && hit(req.addr, IRQ_STAT_OFS)) begin
            irq_stat_q <= irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);
    // read mux, registered data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (req.sel && !req.en && !req.wr) begin
            case (req.addr)
                CONTROL_OFS: prdata <= {24'h0, pend_q, acken_q, start_q, stop_q, wcol_q, en_q,
                                        2'b00};
                // code in the upper bits, prescaler low
                STATUS_OFS: prdata <= {24'h0, code_q, 1'b0, presc_q};
                SHIFT_OFS: prdata <= {24'h0, shift_q};
                ADDR_OFS: prdata <= {25'h0, own_q};
                DIV_OFS: prdata <= {{(32-DIV_W){1'b0}}, div_q};
                // events landing at this edge are reported too, since the access clears them
                IRQ_STAT_OFS: prdata <= {29'h0, irq_stat_q | irq_ev};
                IRQ_MASK_OFS: prdata <= {29'h0, irq_mask_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
    // ------------------------------------------------------------
    // bit engine
    // ------------------------------------------------------------
    phase_t ph_q;
    logic [DIV_W-1:0] tick_q;
    logic [1:0] sub_q;
    logic [3:0] bit_q;
    logic master_q;
    logic is_addr_q;
    logic rx_q;
    logic ack_bit_q;
    logic tick;
    pin_out_t pins_q;
    assign tick = (tick_q == '0);
    always_ff @(posedge ref_clk) begin
        if (rst || !master_q) begin
            tick_q <= div_q;
        end else if (tick) begin
            tick_q <= div_q;
        end else begin
            tick_q <= tick_q - 1'b1;
        end
    end
    assign scl_o = pins_q.scl_o;
    assign scl_oe = pins_q.scl_oe;
    assign sda_o = pins_q.sda_o;
    assign sda_oe = pins_q.sda_oe;
    // post outputs for the sequencer
    always_comb begin
        post = 1'b0;
        post_code = ST_IDLE;
        stop_done = 1'b0;
        if (master_q && tick) begin
            if (ph_q == PH_START && sub_q == 2'd2) begin
                post = 1'b1;
                post_code = is_addr_q ? ST_RSTART : ST_START;
            // byte out, ack in, then posted
            end else if (ph_q == PH_ACK && sub_q == 2'd2) begin
                post = 1'b1;
                if (is_addr_q) begin
                    post_code = rx_q ? (ack_bit_q ? ST_SLAR_NACK : ST_SLAR_ACK)
                                     : (ack_bit_q ? ST_SLAW_NACK : ST_SLAW_ACK);
                end else begin
                    post_code = rx_q ? (ack_bit_q ? ST_DATR_NACK : ST_DATR_ACK)
                                     : (ack_bit_q ? ST_DATW_NACK : ST_DATW_ACK);
                end
            end else if (ph_q == PH_STOP && sub_q == 2'd2) begin
                stop_done = 1'b1;
            end
        end else if (!master_q && ph_q == PH_ACK && scl_fall
                     && (!is_addr_q || shift_q[7:1] == own_q)) begin
            // slave roles post after their ack slot
            post = 1'b1;
            if (is_addr_q) begin
                post_code = rx_q ? ST_ST_ADDR : ST_SR_ADDR;
            end else begin
                post_code = rx_q ? (ack_bit_q ? ST_ST_DATA_NACK : ST_ST_DATA_ACK)
                                 : (ack_bit_q ? ST_SR_DATA_NACK : ST_SR_DATA_ACK);
            end
        end else if (!master_q && ph_q == PH_SLAVE && bus_stop) begin
            post = 1'b1;
            post_code = ST_SR_STOP;
        end
    end
    // one sequencer serves all four roles
    always_ff @(posedge ref_clk) begin
        if (rst || !en_q) begin
            ph_q <= PH_IDLE;
            sub_q <= 2'd0;
            bit_q <= 4'd0;
            master_q <= 1'b0;
            is_addr_q <= 1'b0;
            rx_q <= 1'b0;
            ack_bit_q <= 1'b1;
            shift_q <= 8'h00;
            pins_q <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
        end else begin
            if (shift_wr && pend_q) begin
                shift_q <= req.wdata[7:0];
            end
            case (ph_q)
                PH_IDLE: begin
                    if (start_q && !pend_q && scl && sda) begin
                        master_q <= 1'b1;
                        is_addr_q <= 1'b0;
                        ph_q <= PH_START;
                        sub_q <= 2'd0;
                    end else if (bus_start) begin
                        ph_q <= PH_BITS;
                        is_addr_q <= 1'b1;
                        rx_q <= 1'b1;
                        bit_q <= 4'd0;
                    end
                end
                PH_START: if (tick) begin
                    // release both lines then pull sda low with scl high
                    sub_q <= sub_q + 2'd1;
                    pins_q.scl_oe <= (sub_q == 2'd2);
                    pins_q.sda_oe <= (sub_q != 2'd0);
                    if (sub_q == 2'd2) begin
                        is_addr_q <= 1'b1;
                        ph_q <= PH_HOLD;
                    end
                end
                PH_HOLD: if (!pend_q) begin
                    sub_q <= 2'd0;
                    bit_q <= 4'd0;
                    // stop on request; repeated start keeps bus
                    if (stop_q) begin
                        ph_q <= PH_STOP;
                    end else if (start_q) begin
                        is_addr_q <= 1'b1;
                        ph_q <= PH_START;
                    end else begin
                        if (is_addr_q && code_q inside {ST_START, ST_RSTART}) begin
                            // direction bit sets read or write
                            rx_q <= shift_q[0];
                        end else begin
                            is_addr_q <= 1'b0;
                        end
                        ph_q <= PH_BITS;
                    end
                end
                // a stop from the far master ends the slave transfer
                PH_BITS: if (!master_q && bus_stop) begin
                    ph_q <= PH_IDLE;
                end else if (master_q ? tick : (scl_rise || scl_fall)) begin
                    if (master_q) begin
                        sub_q <= sub_q + 2'd1;
                        pins_q.scl_oe <= !(sub_q == 2'd1 || sub_q == 2'd2);
                        if (sub_q == 2'd0) begin
                            pins_q.sda_oe <= (rx_q && !is_addr_q) ? 1'b0 : !shift_q[7];
                        end
                    end
                    if (master_q ? (sub_q == 2'd1) : scl_rise) begin
                        shift_q <= {shift_q[6:0], sda};
                        bit_q <= bit_q + 4'd1;
                    end
                    if (!master_q && scl_fall && bit_q == 4'd8) begin
                        // eighth bit done, ack slot follows
                        ph_q <= PH_ACK;
                        if (is_addr_q) begin
                            rx_q <= shift_q[0];
                        end
                        pins_q.sda_oe <= is_addr_q ? (shift_q[7:1] == own_q) : (acken_q && !rx_q);
                    end else if (!master_q && scl_fall && rx_q && !is_addr_q) begin
                        pins_q.sda_oe <= !shift_q[7];
                    end
                    if (master_q && sub_q == 2'd3 && bit_q == 4'd8) begin
                        ph_q <= PH_ACK;
                        pins_q.sda_oe <= rx_q && !is_addr_q && acken_q;
                    end
                end
                PH_ACK: if (master_q ? tick : (scl_rise || scl_fall)) begin
                    if (master_q) begin
                        sub_q <= sub_q + 2'd1;
                        pins_q.scl_oe <= !(sub_q == 2'd0 || sub_q == 2'd1);
                        if (sub_q == 2'd1) begin
                            ack_bit_q <= sda;
                        end
                        if (sub_q == 2'd2) begin
                            ph_q <= PH_HOLD;
                            pins_q.sda_oe <= 1'b0;
                        end
                    end else if (scl_rise) begin
                        ack_bit_q <= sda;
                    end else begin
                        // stretch scl low while software services the slave
                        pins_q.sda_oe <= 1'b0;
                        pins_q.scl_oe <= (shift_q[7:1] == own_q) || !is_addr_q;
                        ph_q <= ((shift_q[7:1] == own_q) || !is_addr_q) ? PH_SLAVE : PH_IDLE;
                    end
                end
                PH_SLAVE: begin
                    if (bus_stop) begin
                        ph_q <= PH_IDLE;
                        pins_q.scl_oe <= 1'b0;
                    end else if (!pend_q) begin
                        pins_q.scl_oe <= 1'b0;
                        pins_q.sda_oe <= rx_q && !shift_q[7];
                        is_addr_q <= 1'b0;
                        bit_q <= 4'd0;
                        ph_q <= PH_BITS;
                    end
                end
                PH_STOP: if (tick) begin
                    // sda low, scl released, then sda released
                    sub_q <= sub_q + 2'd1;
                    pins_q.sda_oe <= (sub_q != 2'd2);
                    pins_q.scl_oe <= (sub_q == 2'd0);
                    if (sub_q == 2'd2) begin
                        ph_q <= PH_IDLE;
                        master_q <= 1'b0;
                    end
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end
endmodule // two_wire_mode_status_sequencer

// ===== two_wire_props.sv
// checker: port-level properties of the two-wire unit
module two_wire_props
    import two_wire_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // bus answer, pins and interrupt tied to their causes
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_unmapped_err: assert property (psel && penable && paddr > IRQ_MASK_OFS |-> pslverr)
        else $error("no error on unmapped access");
    chk_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'b00
        && paddr <= IRQ_MASK_OFS |-> !pslverr) else $error("error on mapped access");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !scl_oe && !sda_oe && !irq)
        else $error("outputs active after reset");
    chk_open_drain: assert property (!scl_o && !sda_o)
        else $error("pin driven high");
    chk_scl_low_min: assert property ($rose(scl_oe) |=> scl_oe)
        else $error("clock low phase too short");
    chk_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    chk_irq_drop_cause: assert property ($fell(irq) |->
        $past(psel && penable && (pwrite || paddr == IRQ_STAT_OFS)))
        else $error("irq fell without access");
endmodule // two_wire_props

// ===== bus_slave_model.sv
// partner: open-drain bus slave that acknowledges its own address
module bus_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    output logic [7:0] last_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    logic first = 1'b0;
    logic [7:0] sh = 8'h00;
    initial sda_pull = 1'b0;
    // start or repeated start restarts at the address byte
    always @(negedge sda) if (scl) begin
        n = 0;
        first = 1'b1;
    end
    // eight bits msb first with direction last, then the slot
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        n = n + 1;
    end
    // ack pulls low in the slot, a foreign address is left high
    always @(negedge scl) begin
        if (n == 8) begin
            last_byte = sh;
            sda_pull = !first || sh[7:1] == ADDR;
            first = 1'b0;
        end else begin
            sda_pull = 1'b0;
            if (n == 9) n = 0;
        end
    end
endmodule // bus_slave_model

// ===== tb_two_wire_mode_status_sequencer.sv
// testbench: register access, master write sequence, status posts, interrupt
module tb_two_wire_mode_status_sequencer;
    import two_wire_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, pull, err;
    logic mscl = 1'b0, msda = 1'b0;
    logic [7:0] last_byte;
    // far master pulls share the lines with the block and the slave model
    wire scl = !(scl_oe || mscl);
    wire sda = !(sda_oe || pull || msda);
    int miscompares = 0, checks_done = 0;
    localparam logic [31:0] EN = 32'h1 << CTL_EN, PD = 32'h1 << CTL_PEND;
    localparam logic [31:0] STA = 32'h1 << CTL_START, STP = 32'h1 << CTL_STOP;
    localparam logic [6:0] SLV = 7'h2A;
    localparam logic [31:0] ACK = 32'h1 << CTL_ACKEN;
    two_wire_mode_status_sequencer two_wire_mode_status_sequencer_inst (.ref_clk, .rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .scl_i(scl), .sda_i(sda), .scl_o, .scl_oe, .sda_o, .sda_oe, .irq);
    bus_slave_model #(.ADDR(SLV)) bus_slave_model_inst (.scl, .sda, .sda_pull(pull),
        .last_byte);
    initial forever #25 ref_clk = !ref_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; data and error taken at the ready edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next request never restarts in this step
        @(posedge ref_clk);
    endtask
    // look at irq mid-cycle, away from the launching edge
    task automatic chk_irq(input logic e);
        @(negedge ref_clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge ref_clk);
    endtask
    // write control, poll until pending, compare masked code
    task automatic post(input logic [31:0] ctl, input logic [4:0] code);
        int k;
        k = 0;
        apb(1'b1, CONTROL_OFS, ctl);
        do begin
            apb(1'b0, CONTROL_OFS, 32'h0);
            k++;
        end while (rv[CTL_PEND] !== 1'b1 && k < 3000);
        chk(rv & PD, PD);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rv & STATUS_MASK, {24'h0, code, 3'h0});
    endtask
    task automatic t_regs();
        apb(1'b1, STATUS_OFS, 32'h3);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rv, {24'h0, ST_IDLE, 3'h3});
        apb(1'b0, 12'h01C, 32'h0);
        chk({rv[30:0], err}, 32'h1);
        apb(1'b1, IRQ_MASK_OFS, 32'h1);
        apb(1'b1, CONTROL_OFS, EN);
        apb(1'b1, SHIFT_OFS, 32'h55);
        apb(1'b0, CONTROL_OFS, 32'h0);
        chk(rv, EN | 32'h8);
        chk_irq(1'b0);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rv & 32'h2, 32'h2);
        apb(1'b1, CONTROL_OFS, EN);
    endtask
    task automatic t_master();
        apb(1'b1, DIV_OFS, 32'h2);
        post(PD | STA | EN, ST_START);
        chk_irq(1'b1);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rv & 32'h1, 32'h1);
        chk_irq(1'b0);
        apb(1'b1, SHIFT_OFS, {24'h0, SLV, 1'b0});
        post(PD | EN, ST_SLAW_ACK);
        apb(1'b1, SHIFT_OFS, 32'hA5);
        post(PD | EN, ST_DATW_ACK);
        chk({24'h0, last_byte}, 32'hA5);
        apb(1'b1, CONTROL_OFS, EN);
        repeat (40) @(posedge ref_clk);
        apb(1'b0, CONTROL_OFS, 32'h0);
        chk(rv & PD, PD);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rv & STATUS_MASK, {24'h0, ST_DATW_ACK, 3'h0});
        post(PD | STA | EN, ST_RSTART);
        apb(1'b1, SHIFT_OFS, {24'h0, SLV ^ 7'h01, 1'b0});
        post(PD | EN, ST_SLAW_NACK);
        apb(1'b1, CONTROL_OFS, PD | STP | EN);
        repeat (200) @(posedge ref_clk);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rv & 32'h4, 32'h4);
        chk({30'h0, scl, sda}, 32'h3);
    endtask
    // far master sends one byte msb first, then the block must ack in the slot
    task automatic lbyte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--) begin
            msda <= (i > 0) ? !b[i-1] : 1'b0;
            repeat (8) @(posedge ref_clk);
            mscl <= 1'b0;
            repeat (4) @(posedge ref_clk);
            if (i == 0) chk({31'h0, sda_oe}, 32'h1);
            repeat (4) @(posedge ref_clk);
            mscl <= 1'b1;
        end
    endtask
    // a far master writes one byte to our own address, then stops
    task automatic t_slave();
        apb(1'b1, ADDR_OFS, 32'h35);
        msda <= 1'b1;
        repeat (8) @(posedge ref_clk);
        mscl <= 1'b1;
        lbyte(8'h6A);
        post(EN | ACK, ST_SR_ADDR);
        chk({31'h0, scl_oe}, 32'h1);
        apb(1'b1, CONTROL_OFS, PD | EN | ACK);
        lbyte(8'h3C);
        post(EN | ACK, ST_SR_DATA_ACK);
        apb(1'b0, SHIFT_OFS, 32'h0);
        chk(rv, 32'h3C);
        apb(1'b1, CONTROL_OFS, PD | EN);
        msda <= 1'b1;
        repeat (8) @(posedge ref_clk);
        mscl <= 1'b0;
        repeat (8) @(posedge ref_clk);
        msda <= 1'b0;
        repeat (8) @(posedge ref_clk);
        post(PD | STA | EN, ST_START);
        apb(1'b1, CONTROL_OFS, PD | STP | EN);
    endtask
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_master();
        t_slave();
        summarize();
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule // tb_two_wire_mode_status_sequencer
bind two_wire_mode_status_sequencer two_wire_props #(.DIV_W(DIV_W)) two_wire_props_inst (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .scl_i, .sda_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .irq);
